// ---- include/tmr_pkg.sv ----
// constants and types of the dual 16-bit timer counter block
package tmr_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [19:0] ADDR_POL0   = 20'h0_f0275;
	localparam logic [19:0] ADDR_CNT0   = 20'h0_f0276;
	localparam logic [19:0] ADDR_POL1   = 20'h0_f0285;
	localparam logic [19:0] ADDR_CNT1   = 20'h0_f0286;
	localparam logic [19:0] ADDR_CTRL   = 20'h0_f0290;
	localparam logic [19:0] ADDR_STAT   = 20'h0_f0292;
	localparam logic [19:0] ADDR_CLR    = 20'h0_f0294;
	localparam logic [19:0] ADDR_IRQ_EN = 20'h0_f0296;

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int POL_B_BIT      = 0;    // polarity_out_b
	localparam int POL_C_BIT      = 1;    // polarity_out_c
	localparam int POL_D_BIT      = 2;    // polarity_out_d
	localparam int CTRL_MODE_LSB  = 0;    // mode field, 3 bits
	localparam int CTRL_START_LSB = 4;    // start bits ch0, ch1
	localparam int ST_OVF0_BIT    = 0;    // overflow_flag ch0
	localparam int ST_OVF1_BIT    = 1;    // overflow_flag ch1
	localparam int ST_UDF1_BIT    = 2;    // underflow_flag ch1
	localparam logic [7:0]  POL_RESET  = 8'h00;
	localparam logic [15:0] CNT_RESET  = 16'h0000;
	localparam logic [15:0] CNT_MAX    = 16'hffff;
	localparam logic [15:0] CNT_ONE    = 16'h0001;
	localparam logic [7:0]  CTRL_RESET = 8'h00;
	localparam logic [2:0]  ST_RESET   = 3'h0;

	// ----------------------------------------
	// operating modes
	// ----------------------------------------
	typedef enum logic [2:0] {
		MODE_TIMER,
		MODE_PWM,
		MODE_RSYNC,
		MODE_THREE_OUTPUT_PWM_MODE,
		MODE_COMP
	} mode_t;
endpackage

// ---- rtl/tmr_counter_pwm_pol.sv ----
// dual 16-bit counter with pwm output polarity and flag logic
//
// Function
// - polarity acts only in plain pwm function
// - second counter idle in rsync and three_output_pwm_mode
// - first counter counts up only there
// - first counter overflow sets its flag
// - complementary mode counters count up or down
// - second counter underflow sets its flag
// - counters reset 0000H, polarity 00H
// - no count without timer clock enable
// - wrap FFFFH to 0000H sets overflow, clears too
// - underflow flag only in complementary mode
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module tmr_counter_pwm_pol
	import tmr_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [19:0] addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr_stb,
	input  wire logic        rd_stb,
	output logic      [15:0] rdata,
	input  wire logic [1:0]  count_tick,
	input  wire logic [1:0]  count_down,
	input  wire logic [1:0]  count_clear,
	input  wire logic [2:0]  pwm_raw_ch0,
	input  wire logic [2:0]  pwm_raw_ch1,
	input  wire logic        option_hs_clock_select,
	input  wire logic        timer_clock_enable,
	output logic      [2:0]  output_pins_ch0,
	output logic      [2:0]  output_pins_ch1,
	output logic             irq
);

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	logic [7:0]  pol_reg   [2];   // pwm_polarity_ctrl per channel
	logic [15:0] cnt_reg   [2];   // timer_count per channel
	logic [15:0] cnt_next  [2];   // counter next values
	logic [7:0]  ctrl_reg;        // mode and start bits
	logic [2:0]  stat_reg;        // sticky event flags
	logic [2:0]  stat_next;       // flags next value
	logic [2:0]  irq_en_reg;      // interrupt enables
	logic [15:0] rdata_reg;       // read data holding
	logic [15:0] rdata_next;      // read mux result
	logic [2:0]  pin_reg   [2];   // registered pin levels
	logic        irq_reg;         // registered interrupt
	logic [1:0]  hs_sync_reg;     // option select synchroniser
	logic [1:0]  en_sync_reg;     // clock enable synchroniser

	// ----------------------------------------
	// decode
	// ----------------------------------------
	// unused mode codes decode to none of the named modes and act as timer mode
	wire mode_t mode      = mode_t'(ctrl_reg[CTRL_MODE_LSB +: 3]);
	wire        in_pwm    = (mode == MODE_PWM);
	wire        in_comp   = (mode == MODE_COMP);
	wire        in_upmode = (mode == MODE_RSYNC) || (mode == MODE_THREE_OUTPUT_PWM_MODE);
	wire [1:0]  start     = ctrl_reg[CTRL_START_LSB +: 2];
	wire        hs_sel    = hs_sync_reg[1];
	wire        clk_en    = en_sync_reg[1];
	// a disabled timer clock freezes everything that counts
	wire        run_ok    = clk_en;
	// exact address match; no byte lanes, so no partial hits
	wire        hit_pol0  = (addr == ADDR_POL0);
	wire        hit_cnt0  = (addr == ADDR_CNT0);
	wire        hit_pol1  = (addr == ADDR_POL1);
	wire        hit_cnt1  = (addr == ADDR_CNT1);
	wire        hit_ctrl  = (addr == ADDR_CTRL);
	wire        hit_stat  = (addr == ADDR_STAT);
	wire        hit_clr   = (addr == ADDR_CLR);
	wire        hit_irqen = (addr == ADDR_IRQ_EN);
	// per channel write enables for counter and polarity
	wire [1:0]  wr_cnt    = {wr_stb && hit_cnt1, wr_stb && hit_cnt0};
	wire [1:0]  wr_pol    = {wr_stb && hit_pol1, wr_stb && hit_pol0};
	// raw levels gathered per channel for the generate loop
	wire [2:0]  raw       [2];
	assign raw[0] = pwm_raw_ch0;
	assign raw[1] = pwm_raw_ch1;

	// ----------------------------------------
	// per channel counters and polarity
	// ----------------------------------------
	logic [1:0] ovf_ev;   // FFFFH to 0000H wrap per channel
	logic [1:0] udf_ev;   // 0000H to FFFFH wrap per channel
	logic [1:0] active;   // channel allowed to count
	logic [1:0] dir_dn;   // channel counting down

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_ch
			// second channel sits idle in the single-counter modes
			assign active[g] = start[g] && run_ok
				&& !(g == 1 && in_upmode);
			// only complementary mode may count down
			assign dir_dn[g] = in_comp && count_down[g];
			// one count step when a tick meets an active channel
			wire step = active[g] && count_tick[g];
			// end points for wrap detection
			wire at_max = (cnt_reg[g] == CNT_MAX);
			wire at_min = (cnt_reg[g] == CNT_RESET);
			// a clear from compare or capture at FFFFH still wraps
			assign ovf_ev[g] = step && !wr_cnt[g] && at_max
				&& (!dir_dn[g] || count_clear[g]);
			// a clear at 0000H while counting down is no underflow
			assign udf_ev[g] = step && !wr_cnt[g] && dir_dn[g]
				&& !count_clear[g] && at_min;

			// next count: write beats counting, clear beats step
			always_comb
			begin
				cnt_next[g] = cnt_reg[g];
				if (wr_cnt[g])
				begin
					// full word only, byte lanes not offered
					cnt_next[g] = wdata;
				end
				else if (step && count_clear[g])
				begin
					cnt_next[g] = CNT_RESET;
				end
				else if (step && dir_dn[g])
				begin
					cnt_next[g] = cnt_reg[g] - CNT_ONE;
				end
				else if (step)
				begin
					cnt_next[g] = cnt_reg[g] + CNT_ONE;
				end
			end

			// counter and polarity storage
			always_ff @(posedge clk or negedge nrst)
			begin
				if (!nrst)
				begin
					cnt_reg[g] <= CNT_RESET;
					pol_reg[g] <= POL_RESET;
				end
				else
				begin
					cnt_reg[g] <= cnt_next[g];
					if (wr_pol[g])
					begin
						// only the three defined bits are kept
						pol_reg[g] <= {5'h0_0, wdata[2:0]};
					end
				end
			end

			// polarity: 0 inverts to low active, 1 passes high active
			wire [2:0] pol_bits = {pol_reg[g][POL_D_BIT],
				pol_reg[g][POL_C_BIT], pol_reg[g][POL_B_BIT]};
			wire [2:0] shaped = in_pwm ? ~(raw[g] ^ pol_bits)
				: raw[g];

			// pins straight from flops
			always_ff @(posedge clk or negedge nrst)
			begin
				if (!nrst)
				begin
					// pins idle low until the first clock after reset
					pin_reg[g] <= 3'h0;
				end
				else
				begin
					pin_reg[g] <= shaped;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// status flags
	// ----------------------------------------
	// set wins over a clear arriving in the same cycle
	wire [2:0] clr_mask = (wr_stb && hit_clr) ? wdata[2:0] : 3'h0;
	wire [2:0] set_mask = {
		udf_ev[1] && in_comp,
		ovf_ev[1],
		ovf_ev[0]
	};

	always_comb
	begin
		// flags stay set until software writes a one to clear them
		stat_next = (stat_reg & ~clr_mask) | set_mask;
	end

	// ----------------------------------------
	// control, enables, synchronisers
	// ----------------------------------------
	// option select and clock enable come from other clock logic
	// two stages each against metastability; only the second is read
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			hs_sync_reg <= 2'h0;
			en_sync_reg <= 2'h0;
		end
		else
		begin
			hs_sync_reg <= {hs_sync_reg[0], option_hs_clock_select};
			en_sync_reg <= {en_sync_reg[0], timer_clock_enable};
		end
	end

	// software control registers
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl_reg   <= CTRL_RESET;
			irq_en_reg <= ST_RESET;
			stat_reg   <= ST_RESET;
		end
		else
		begin
			// status moves every cycle, bus registers only on a strobe
			stat_reg <= stat_next;
			if (wr_stb && hit_ctrl)
			begin
				ctrl_reg <= wdata[7:0];
			end
			if (wr_stb && hit_irqen)
			begin
				irq_en_reg <= wdata[2:0];
			end
		end
	end

	// ----------------------------------------
	// read path and interrupt
	// ----------------------------------------
	// unmapped addresses read as zero
	always_comb
	begin
		rdata_next = 16'h0000;
		if (hit_pol0)
		begin
			rdata_next = {8'h00, pol_reg[0]};
		end
		else if (hit_cnt0)
		begin
			rdata_next = cnt_reg[0];
		end
		else if (hit_pol1)
		begin
			rdata_next = {8'h00, pol_reg[1]};
		end
		else if (hit_cnt1)
		begin
			rdata_next = cnt_reg[1];
		end
		// control read carries the synchronised clock select in bit 8
		else if (hit_ctrl)
		begin
			rdata_next = {7'h00, hs_sel, ctrl_reg};
		end
		else if (hit_stat)
		begin
			rdata_next = {13'h0000, stat_reg};
		end
		else if (hit_irqen)
		begin
			rdata_next = {13'h0000, irq_en_reg};
		end
	end

	// read data held valid only in the cycle after the strobe
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rdata_reg <= 16'h0000;
			irq_reg   <= 1'b0;
		end
		else
		begin
			rdata_reg <= rd_stb ? rdata_next : 16'h0000;
			// next status used so irq rises together with the flag
			irq_reg   <= |(stat_next & irq_en_reg);
		end
	end

	// outputs are plain flop copies, no logic after the flops
	assign rdata           = rdata_reg;
	assign irq             = irq_reg;
	assign output_pins_ch0 = pin_reg[0];
	assign output_pins_ch1 = pin_reg[1];

endmodule
`default_nettype wire

// ---- test/tmr_counter_pwm_pol_monitor.sv ----
// port checker of the timer counter block
`timescale 1ns/1ns
`default_nettype none
module tmr_counter_pwm_pol_monitor
	import tmr_pkg::*;
(
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [19:0] addr,
	input wire logic [15:0] wdata,
	input wire logic        wr_stb,
	input wire logic        rd_stb,
	input wire logic [15:0] rdata,
	input wire logic [1:0]  count_tick,
	input wire logic [2:0]  pwm_raw_ch0,
	input wire logic [2:0]  pwm_raw_ch1,
	input wire logic [2:0]  output_pins_ch0,
	input wire logic [2:0]  output_pins_ch1,
	input wire logic        irq
);
	// ----------------------------------------
	// shadows of written control state
	// ----------------------------------------
	logic [2:0] mode_reg;  // mode last written
	logic [2:0] pol0_reg;  // ch0 polarity last written
	logic [2:0] en_reg;    // enables last written
	logic       polw_reg;  // any polarity write seen
	wire        pol_rd = rd_stb && (addr == ADDR_POL0 || addr == ADDR_POL1);
	// shadows follow the bus, so they track the block without seeing inside it
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			mode_reg <= 3'h0;
			pol0_reg <= 3'h0;
			en_reg <= 3'h0;
			polw_reg <= 1'b0;
		end
		else if (wr_stb)
		begin
			if (addr == ADDR_CTRL)
				mode_reg <= wdata[2:0];
			if (addr == ADDR_POL0)
				pol0_reg <= wdata[2:0];
			if (addr == ADDR_IRQ_EN)
				en_reg <= wdata[2:0];
			if (addr == ADDR_POL0 || addr == ADDR_POL1)
				polw_reg <= 1'b1;
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_cnt_wr; wr_stb && addr == ADDR_CNT0; endsequence
	sequence s_cnt_rd; rd_stb && addr == ADDR_CNT0 && !count_tick[0]; endsequence
	property p_pwm_pol; $past(nrst) && $past(mode_reg) == MODE_PWM |->
		output_pins_ch0 == ~($past(pwm_raw_ch0) ^ $past(pol0_reg)); endproperty
	property p_raw; $past(nrst) && $past(mode_reg) != MODE_PWM |->
		output_pins_ch0 == $past(pwm_raw_ch0) && output_pins_ch1 == $past(pwm_raw_ch1); endproperty
	property p_idle; !$past(rd_stb) |-> rdata == 16'h0000; endproperty
	property p_pol_hi; $past(pol_rd) |-> rdata[15:3] == 13'h0000; endproperty
	property p_pol_rst; $past(pol_rd) && !polw_reg |-> rdata == 16'h0000; endproperty
	property p_stat_hi; $past(rd_stb && addr == ADDR_STAT) |-> rdata[15:3] == 13'h0000; endproperty
	property p_cnt_hold; s_cnt_wr ##1 (!wr_stb && !count_tick[0]) ##1 s_cnt_rd |=>
		rdata == $past(wdata, 3); endproperty
	property p_irq_off; en_reg == 3'h0 && $past(en_reg) == 3'h0 |-> !irq; endproperty
	a_pwm_pol: assert property (p_pwm_pol) else $error("pin level wrong for polarity");
	a_raw: assert property (p_raw) else $error("polarity acted outside pwm");
	a_idle: assert property (p_idle) else $error("read data outside read slot");
	a_pol_hi: assert property (p_pol_hi) else $error("polarity upper bits set");
	a_pol_rst: assert property (p_pol_rst) else $error("polarity not reset");
	a_stat_hi: assert property (p_stat_hi) else $error("status upper bits set");
	a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved without tick");
	a_irq_off: assert property (p_irq_off) else $error("irq without enable");
endmodule
bind tmr_counter_pwm_pol tmr_counter_pwm_pol_monitor i_tmr_counter_pwm_pol_monitor (.clk, .nrst, .addr, .wdata,
	.wr_stb, .rd_stb, .rdata, .count_tick, .pwm_raw_ch0, .pwm_raw_ch1, .output_pins_ch0, .output_pins_ch1, .irq);
`default_nettype wire

// ---- test/tmr_pin_load.sv ----
// behavioural model of the loads on the timer output pins
`timescale 1ns/1ns
`default_nettype none
module tmr_pin_load
(
	input  wire logic       clk,
	input  wire logic [2:0] pins_ch0,
	input  wire logic [2:0] pins_ch1,
	output logic      [5:0] seen
);
	// each load follows its pin one clock late, as a slow input stage would
	always @(posedge clk)
		seen <= {pins_ch1, pins_ch0};
endmodule
`default_nettype wire

// ---- test/timer_counter_pwm_polarity_bench.sv ----
// self-checking bench of the timer counter block
`timescale 1ns/1ns
`default_nettype none
module timer_counter_pwm_polarity_bench import tmr_pkg::*;;
	logic        clk = 0, nrst = 0, wr_stb = 0, rd_stb = 0, rd_d = 0, irq;
	logic [19:0] addr = '0;
	logic [15:0] wdata = '0, rdata;
	logic [1:0]  count_tick = '0, count_down = '0, count_clear = '0;
	logic [2:0]  pwm_raw_ch0 = '0, pwm_raw_ch1 = '0, output_pins_ch0, output_pins_ch1;
	logic [5:0]  load_seen, x;
	logic        clk_en_in = 1'b1, hs_sel_in = 1'b0;  // timer clock enable and clock select levels
	logic [31:0] seed = 32'h0000_c126;
	logic [15:0] exp_q[$];  // expected read data, oldest first
	mode_t       m;
	int          fail_count = 0, total_checks = 0;
	tmr_counter_pwm_pol i_tmr_counter_pwm_pol (.clk, .nrst, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .count_tick,
		.count_down, .count_clear, .pwm_raw_ch0, .pwm_raw_ch1, .option_hs_clock_select(hs_sel_in),
		.timer_clock_enable(clk_en_in), .output_pins_ch0, .output_pins_ch1, .irq);
	tmr_pin_load i_tmr_pin_load (.clk, .pins_ch0(output_pins_ch0), .pins_ch1(output_pins_ch1), .seen(load_seen));
	always #50 clk = ~clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// pin levels as the loads see them
	task automatic chk_pins(input logic [5:0] e);
		chk({10'h000, load_seen}, {10'h000, e});
	endtask
	// interrupt level
	task automatic chk_irq(input logic e);
		chk({15'h0000, irq}, {15'h0000, e});
	endtask
	// whole 16-bit words only; the bus has no byte lanes
	task automatic wr(input logic [19:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [19:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd_stb <= 1'b0;
	endtask
	task automatic tk(input logic [1:0] t, input logic [1:0] dn, input logic [1:0] cl);
		@(posedge clk);
		count_tick <= t;
		count_down <= dn;
		count_clear <= cl;
		@(posedge clk);
		count_tick <= 2'h0;
		count_clear <= 2'h0;
	endtask
	// read data stand one cycle after the strobe; compare them there
	always @(posedge clk)
	begin
		if (rd_d && exp_q.size() > 0)
			chk(rdata, exp_q.pop_front());
		rd_d <= rd_stb;
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		#200_000;
		fail_count++;
		final_report();
	end
	initial
	begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		rd(ADDR_POL0, 16'h0000);
		rd(ADDR_CNT1, 16'h0000);
		wr(ADDR_CNT0, 16'h1234);
		rd(ADDR_CNT0, 16'h1234);
		wr(ADDR_IRQ_EN, 16'h0007);
		wr(ADDR_CNT0, 16'hffff);
		wr(ADDR_CNT1, 16'h0005);
		wr(ADDR_CTRL, 16'h0032);
		tk(2'h3, 2'h0, 2'h0);
		rd(ADDR_CNT0, 16'h0000);
		rd(ADDR_CNT1, 16'h0005);
		rd(ADDR_STAT, 16'h0001);
		chk_irq(1'b1);
		wr(ADDR_CLR, 16'h0007);
		wr(ADDR_CNT0, 16'h0002);
		wr(ADDR_CNT1, 16'h0000);
		wr(ADDR_CTRL, 16'h0034);
		tk(2'h3, 2'h3, 2'h0);
		rd(ADDR_CNT0, 16'h0001);
		rd(ADDR_CNT1, 16'hffff);
		rd(ADDR_STAT, 16'h0004);
		wr(ADDR_CLR, 16'h0007);
		wr(ADDR_CNT1, 16'h0000);
		wr(ADDR_CTRL, 16'h0020);
		tk(2'h3, 2'h2, 2'h0);
		rd(ADDR_CNT0, 16'h0001);
		rd(ADDR_CNT1, 16'h0001);
		rd(ADDR_STAT, 16'h0000);
		wr(ADDR_CNT1, 16'hffff);
		tk(2'h2, 2'h0, 2'h2);
		rd(ADDR_CNT1, 16'h0000);
		rd(ADDR_STAT, 16'h0002);
		wr(ADDR_IRQ_EN, 16'h0000);
		repeat (2) @(posedge clk);
		chk_irq(1'b0);
		wr(ADDR_CLR, 16'h0007);
		// clock enable low freezes the counter; clock select shows in control bit 8
		clk_en_in <= 1'b0;
		hs_sel_in <= 1'b1;
		repeat (3) @(posedge clk);
		tk(2'h2, 2'h0, 2'h0);
		rd(ADDR_CNT1, 16'h0000);
		rd(ADDR_CTRL, 16'h0120);
		clk_en_in <= 1'b1;
		repeat (3) @(posedge clk);
		tk(2'h2, 2'h0, 2'h0);
		rd(ADDR_CNT1, 16'h0001);
		// every mode with random polarity, raw levels and unused upper bits
		for (int i = 0; i < 15; i++)
		begin
			seed = lfsr(seed);
			m = mode_t'(i % 5);
			wr(ADDR_POL0, seed[15:0]);
			wr(ADDR_POL1, seed[31:16]);
			wr(ADDR_CTRL, {13'h0000, m});
			pwm_raw_ch0 <= seed[6:4];
			pwm_raw_ch1 <= seed[10:8];
			repeat (3) @(posedge clk);
			x = {seed[10:8], seed[6:4]};
			if (m == MODE_PWM)
				x = ~(x ^ {seed[18:16], seed[2:0]});
			chk_pins(x);
			rd(ADDR_POL0, {13'h0000, seed[2:0]});
		end
		repeat (3) @(posedge clk);
		final_report();
	end
endmodule
`default_nettype wire
